// *** pkg/irq_ctl_pkg.sv ***
package irq_ctl_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int NUM_SRC = 12;                   // Event lines from peripherals
	localparam int NUM_GRP = 10;                   // Enable/priority groups seen by the core
	localparam int MAIN_GRP = 7;                   // Groups held in the main registers

	// ---------------------------------------------------------------
	// Register indices (byte address = index * 4)
	// ---------------------------------------------------------------
	localparam logic [7:0] IDX_ENABLE_MAIN   = 8'ha8;
	localparam logic [7:0] IDX_ENABLE_PRIO_2 = 8'ha9;
	localparam logic [7:0] IDX_PRIORITY_MAIN = 8'hb8;
	localparam logic [7:0] IDX_EVENT_STATUS  = 8'hc0;
	localparam logic [7:0] IDX_EVENT_MASK    = 8'hc1;
	localparam logic [7:0] IDX_CORE_STATE    = 8'hc2;

	// ---------------------------------------------------------------
	// Reset values and writable bits
	// ---------------------------------------------------------------
	localparam logic [7:0]  RST_ENABLE_MAIN   = 8'h00;
	localparam logic [7:0]  RST_ENABLE_PRIO_2 = 8'ha0;
	localparam logic [7:0]  RST_PRIORITY_MAIN = 8'h00;
	localparam logic [11:0] RST_EVENT_MASK    = 12'h000;
	localparam logic [7:0]  WMASK_ENABLE_MAIN = 8'hff;
	localparam logic [7:0]  WMASK_ENABLE_PRIO_2 = 8'h77;
	localparam logic [7:0]  WMASK_PRIORITY_MAIN = 8'h7f;
	localparam logic [7:0]  RDONE_ENABLE_PRIO_2 = 8'h80;   // Reserved bit reading one

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int BIT_GLOBAL_EN = 7;              // Global enable in main enable register
	localparam int SEC_EN_LSB    = 0;              // Secondary enables, bits 2:0
	localparam int SEC_PRIO_LSB  = 4;              // Secondary priorities, bits 6:4
	localparam int SEC_GRP       = 3;              // Groups in the secondary register

	// ---------------------------------------------------------------
	// Event line and group numbers
	// ---------------------------------------------------------------
	localparam int SRC_UART_RX = 4;
	localparam int SRC_UART_TX = 5;
	localparam int SRC_T2_OVF  = 6;
	localparam int SRC_T2_EXT  = 7;
	localparam int GRP_UART    = 4;
	localparam int GRP_TIMER2  = 5;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic       valid;                         // Request to core pending
		logic       high;                          // Level of the request
		logic [3:0] vector;                        // Group number of the winner
	} core_req_t;

	typedef enum logic {
		BUS_IDLE,
		BUS_ANSWER
	} bus_state_t;

endpackage : irq_ctl_pkg

// *** verilog/irq_enable_priority_ctl.sv ***
`timescale 1ns/1ps
module irq_enable_priority_ctl (
	input  wire logic                   CORE_CLK,
	input  wire logic                   SYS_RST,
	input  wire logic                   CLK_EN,
	input  wire logic [9:0]             AVS_ADDRESS,
	input  wire logic                   AVS_READ,
	input  wire logic                   AVS_WRITE,
	input  wire logic [31:0]            AVS_WRITEDATA,
	input  wire logic [3:0]             AVS_BYTEENABLE,
	output logic      [31:0]            AVS_READDATA,
	output logic                        AVS_WAITREQUEST,
	input  wire logic [11:0]            SRC_EVENT,
	input  wire logic                   T2_BAUD_MODE,
	input  wire logic                   CORE_ACK,
	input  wire logic                   CORE_RETI,
	output irq_ctl_pkg::core_req_t      CORE_REQ,
	output logic                        IRQ
);
	import irq_ctl_pkg::*;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------

	// Fold twelve event lines onto the ten groups the core sees
	function automatic logic [NUM_GRP-1:0] group_pending(input logic [NUM_SRC-1:0] st);
		logic [NUM_GRP-1:0] g;
		g = '0;
		g[3:0] = st[3:0];
		g[GRP_UART] = st[SRC_UART_RX] | st[SRC_UART_TX];
		g[GRP_TIMER2] = st[SRC_T2_OVF] | st[SRC_T2_EXT];
		g[9:6] = st[11:8];
		return g;
	endfunction : group_pending

	// Index match on a word-aligned byte address
	function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
		return addr[9:2] == idx;
	endfunction : hit

	// Per-bit write enable from the two low byte lanes
	function automatic logic [11:0] lane_bits(input logic [3:0] be);
		return {{4{be[1]}}, {8{be[0]}}};
	endfunction : lane_bits

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	bus_state_t          bus_state_r;              // Handshake phase
	logic [7:0]          enable_main_r;            // Main enable register
	logic [6:0]          enable_prio_2_r;          // Secondary register, stored bits
	logic [7:0]          priority_main_r;          // Main priority register
	logic [NUM_SRC-1:0]  event_status_r;           // Sticky event bits
	logic [NUM_SRC-1:0]  event_status_nxt;         // Next sticky value
	logic [NUM_SRC-1:0]  event_mask_r;             // Mask for the IRQ line
	logic [NUM_SRC-1:0]  src_prev_r;               // Last sampled event lines
	logic [NUM_SRC-1:0]  src_rise;                 // New events this cycle
	logic                in_service_high_r;        // High-level routine running
	logic                in_service_low_r;         // Low-level routine running
	core_req_t           core_req_r;               // Registered request to core
	core_req_t           core_req_nxt;             // Candidate request
	logic [31:0]         readdata_r;               // Registered read answer
	logic [31:0]         read_mux;                 // Read data selection
	logic [7:0]          enable_prio_2_view;       // Secondary register as read
	logic                bus_req;                  // Read or write pending
	logic                bus_take;                 // Access completes this edge
	logic                wr_take;                  // Write completes this edge
	logic [11:0]         wr_bits;                  // Bits allowed by byteenable
	logic [NUM_GRP-1:0]  grp_enable;               // Per-group enable
	logic [NUM_GRP-1:0]  grp_priority;             // Per-group level, 1 = high
	logic [NUM_GRP-1:0]  grp_armed;                // Pending, enabled, global on
	logic                hi_found;                 // A high-level group armed
	logic                lo_found;                 // A low-level group armed
	logic [3:0]          hi_vec;                   // Lowest armed high group
	logic [3:0]          lo_vec;                   // Lowest armed low group

	// ---------------------------------------------------------------
	// Avalon slave handshake
	// ---------------------------------------------------------------

	// One wait state on every access; read data is ready with the answer
	assign bus_req = AVS_READ | AVS_WRITE;
	assign bus_take = bus_req && bus_state_r == BUS_ANSWER && CLK_EN;
	assign wr_take = bus_take && AVS_WRITE;
	assign wr_bits = lane_bits(AVS_BYTEENABLE);

	// Held high while frozen, so no access completes without state change
	assign AVS_WAITREQUEST = bus_req && !bus_take;
	assign AVS_READDATA = readdata_r;

	// Phase register: answer in the cycle after the request appears
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			bus_state_r <= BUS_IDLE;
		end else if (CLK_EN) begin
			case (bus_state_r)
				BUS_IDLE: begin
					// Request seen, answer next edge
					if (bus_req) begin
						bus_state_r <= BUS_ANSWER;
					end
				end
				BUS_ANSWER: begin
					// Completed; master drops or starts a fresh access
					bus_state_r <= BUS_IDLE;
				end
				default: begin
					bus_state_r <= BUS_IDLE;
				end
			endcase
		end
	end

	// Secondary register view: reserved bit 7 reads one, bit 3 zero
	assign enable_prio_2_view = RDONE_ENABLE_PRIO_2 | {1'b0, enable_prio_2_r};

	// Read selection; unmapped addresses read zero
	always_comb begin
		read_mux = '0;
		if (hit(AVS_ADDRESS, IDX_ENABLE_MAIN)) begin
			read_mux[7:0] = enable_main_r;
		end else if (hit(AVS_ADDRESS, IDX_ENABLE_PRIO_2)) begin
			read_mux[7:0] = enable_prio_2_view;
		end else if (hit(AVS_ADDRESS, IDX_PRIORITY_MAIN)) begin
			read_mux[7:0] = priority_main_r & WMASK_PRIORITY_MAIN;
		end else if (hit(AVS_ADDRESS, IDX_EVENT_STATUS)) begin
			read_mux[NUM_SRC-1:0] = event_status_r;
		end else if (hit(AVS_ADDRESS, IDX_EVENT_MASK)) begin
			read_mux[NUM_SRC-1:0] = event_mask_r;
		end else if (hit(AVS_ADDRESS, IDX_CORE_STATE)) begin
			read_mux[7:0] = {core_req_r.vector, core_req_r.high, core_req_r.valid,
				in_service_high_r, in_service_low_r};
		end
	end

	// Read data captured in the idle phase, stands through the answer
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			readdata_r <= '0;
		end else if (CLK_EN && bus_state_r == BUS_IDLE && AVS_READ) begin
			readdata_r <= read_mux;
		end
	end

	// ---------------------------------------------------------------
	// Enable and priority registers
	// ---------------------------------------------------------------

	// Only lane 0 carries these byte-wide registers
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			enable_main_r <= RST_ENABLE_MAIN;
			enable_prio_2_r <= RST_ENABLE_PRIO_2[6:0];
			priority_main_r <= RST_PRIORITY_MAIN;
		end else if (wr_take && AVS_BYTEENABLE[0]) begin
			if (hit(AVS_ADDRESS, IDX_ENABLE_MAIN)) begin
				enable_main_r <= AVS_WRITEDATA[7:0] & WMASK_ENABLE_MAIN;
			end
			// Bit 3 is never stored, so a stray one there stays harmless
			if (hit(AVS_ADDRESS, IDX_ENABLE_PRIO_2)) begin
				enable_prio_2_r <= AVS_WRITEDATA[6:0] & WMASK_ENABLE_PRIO_2[6:0];
			end
			if (hit(AVS_ADDRESS, IDX_PRIORITY_MAIN)) begin
				priority_main_r <= AVS_WRITEDATA[7:0] & WMASK_PRIORITY_MAIN;
			end
		end
	end

	// ---------------------------------------------------------------
	// Event capture and interrupt line
	// ---------------------------------------------------------------

	// Overflow never counts while Timer 2 is the baud generator
	always_comb begin
		src_rise = SRC_EVENT & ~src_prev_r;
		if (T2_BAUD_MODE) begin
			src_rise[SRC_T2_OVF] = 1'b0;
		end
	end

	// Write one clears; a new event in the same cycle wins
	always_comb begin
		event_status_nxt = event_status_r;
		if (wr_take && hit(AVS_ADDRESS, IDX_EVENT_STATUS)) begin
			event_status_nxt = event_status_r & ~(AVS_WRITEDATA[NUM_SRC-1:0] & wr_bits);
		end
		event_status_nxt = event_status_nxt | src_rise;
	end

	// Edge memory; lines already high at reset release count as new
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			src_prev_r <= '0;
		end else if (CLK_EN) begin
			src_prev_r <= SRC_EVENT;
		end
	end

	// Sticky status
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			event_status_r <= '0;
		end else if (CLK_EN) begin
			event_status_r <= event_status_nxt;
		end
	end

	// Mask for the summary line, same layout as status
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			event_mask_r <= RST_EVENT_MASK;
		end else if (wr_take && hit(AVS_ADDRESS, IDX_EVENT_MASK)) begin
			event_mask_r <= (event_mask_r & ~wr_bits) | (AVS_WRITEDATA[NUM_SRC-1:0] & wr_bits);
		end
	end

	// Level line, combinational from flops only
	assign IRQ = |(event_status_r & event_mask_r);

	// ---------------------------------------------------------------
	// Arbitration toward the core
	// ---------------------------------------------------------------

	// Group enables and levels gathered from the three registers
	assign grp_enable = {enable_prio_2_r[SEC_EN_LSB +: SEC_GRP], enable_main_r[MAIN_GRP-1:0]};
	assign grp_priority = {enable_prio_2_r[SEC_PRIO_LSB +: SEC_GRP], priority_main_r[MAIN_GRP-1:0]};
	assign grp_armed = group_pending(event_status_r) & grp_enable
		& {NUM_GRP{enable_main_r[BIT_GLOBAL_EN]}};

	// Fixed poll order within a level: lowest group number wins
	always_comb begin
		hi_found = 1'b0;
		lo_found = 1'b0;
		hi_vec = '0;
		lo_vec = '0;
		for (int i = NUM_GRP - 1; i >= 0; i--) begin
			if (grp_armed[i] && grp_priority[i]) begin
				hi_found = 1'b1;
				hi_vec = 4'(i);
			end
			if (grp_armed[i] && !grp_priority[i]) begin
				lo_found = 1'b1;
				lo_vec = 4'(i);
			end
		end
	end

	// High may interrupt a low routine; low waits for an idle core
	always_comb begin
		core_req_nxt = '0;
		if (hi_found && !in_service_high_r) begin
			core_req_nxt.valid = 1'b1;
			core_req_nxt.high = 1'b1;
			core_req_nxt.vector = hi_vec;
		end else if (lo_found && !in_service_high_r && !in_service_low_r) begin
			core_req_nxt.valid = 1'b1;
			core_req_nxt.vector = lo_vec;
		end
	end

	// Request dropped for one cycle after an acknowledge so the new
	// in-service level is seen before anything is offered again
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			core_req_r <= '0;
		end else if (CLK_EN) begin
			if (CORE_ACK) begin
				core_req_r <= '0;
			end else begin
				core_req_r <= core_req_nxt;
			end
		end
	end

	assign CORE_REQ = core_req_r;

	// In-service levels: acknowledge enters, return leaves the top one
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			in_service_high_r <= 1'b0;
			in_service_low_r <= 1'b0;
		end else if (CLK_EN) begin
			if (CORE_ACK && core_req_r.valid) begin
				// Entry at the offered level
				if (core_req_r.high) begin
					in_service_high_r <= 1'b1;
				end else begin
					in_service_low_r <= 1'b1;
				end
			end else if (CORE_RETI) begin
				// Return closes the innermost routine
				if (in_service_high_r) begin
					in_service_high_r <= 1'b0;
				end else begin
					in_service_low_r <= 1'b0;
				end
			end
		end
	end

endmodule : irq_enable_priority_ctl

// *** bench/irq_ctl_checker.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker for the enable and priority controller
// ------------------------------------------------------------
module irq_ctl_checker (
	input  wire logic                   CORE_CLK,
	input  wire logic                   SYS_RST,
	input  wire logic [9:0]             AVS_ADDRESS,
	input  wire logic                   AVS_READ,
	input  wire logic                   AVS_WRITE,
	input  wire logic [31:0]            AVS_WRITEDATA,
	input  wire logic [3:0]             AVS_BYTEENABLE,
	input  wire logic [31:0]            AVS_READDATA,
	input  wire logic                   AVS_WAITREQUEST,
	input  wire logic                   CORE_ACK,
	input  wire logic                   CORE_RETI,
	input  wire irq_ctl_pkg::core_req_t CORE_REQ,
	input  wire logic                   IRQ
);
	import irq_ctl_pkg::*;
	logic [7:0] en_sh_r;  // Shadow of main enable
	logic       ins_hi_r; // High routine running
	logic       ins_lo_r; // Low routine running
	logic       done;     // Bus access completes
	logic [7:0] idx;      // Register index
	assign done = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
	assign idx = AVS_ADDRESS[9:2];
	// Shadow follows completed writes only, as the slave does
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST)
			en_sh_r <= 8'h00;
		else if (done && AVS_WRITE && idx == IDX_ENABLE_MAIN && AVS_BYTEENABLE[0])
			en_sh_r <= AVS_WRITEDATA[7:0];
	end
	// In-service levels; return closes high first
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ins_hi_r <= 1'b0;
			ins_lo_r <= 1'b0;
		end else if (CORE_ACK && CORE_REQ.valid) begin
			if (CORE_REQ.high)
				ins_hi_r <= 1'b1;
			else
				ins_lo_r <= 1'b1;
		end else if (CORE_RETI) begin
			if (ins_hi_r)
				ins_hi_r <= 1'b0;
			else
				ins_lo_r <= 1'b0;
		end
	end
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	property p_wait_one;
		$rose(AVS_READ | AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait state count wrong");
	property p_ack_drop;
		CORE_ACK && CORE_REQ.valid |=> !CORE_REQ.valid;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("request stands after ack");
	property p_global;
		!en_sh_r[7] && !$past(en_sh_r[7]) |-> !CORE_REQ.valid;
	endproperty
	a_global: assert property (p_global) else $error("request with global enable clear");
	property p_hi_blocks;
		ins_hi_r |-> !CORE_REQ.valid;
	endproperty
	a_hi_blocks: assert property (p_hi_blocks) else $error("request during high routine");
	property p_lo_blocks;
		ins_lo_r && CORE_REQ.valid |-> CORE_REQ.high;
	endproperty
	a_lo_blocks: assert property (p_lo_blocks) else $error("low request during low routine");
	property p_vector;
		CORE_REQ.valid |-> CORE_REQ.vector < 4'd10;
	endproperty
	a_vector: assert property (p_vector) else $error("vector out of range");
	property p_unmapped;
		done && AVS_READ && !(idx inside {8'ha8, 8'ha9, 8'hb8, 8'hc0, 8'hc1, 8'hc2}) |-> AVS_READDATA == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_prio_rsvd;
		done && AVS_READ && idx == IDX_PRIORITY_MAIN |-> !AVS_READDATA[7];
	endproperty
	a_prio_rsvd: assert property (p_prio_rsvd) else $error("priority bit 7 set");
	property p_sec_rsvd;
		done && AVS_READ && idx == IDX_ENABLE_PRIO_2 |-> AVS_READDATA[7] && !AVS_READDATA[3];
	endproperty
	a_sec_rsvd: assert property (p_sec_rsvd) else $error("secondary reserved bits wrong");
	c_hi_ack: cover property (CORE_ACK && CORE_REQ.valid && CORE_REQ.high);
	c_irq: cover property ($rose(IRQ));
	c_ret: cover property (CORE_RETI && ins_hi_r && ins_lo_r);
endmodule : irq_ctl_checker

// *** bench/core_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Core model: takes a request after a chosen delay
// ------------------------------------------------------------
module core_model (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire irq_ctl_pkg::core_req_t req,
	input  wire logic [3:0]             lat,
	output logic                        ack
);
	import irq_ctl_pkg::*;
	logic [3:0] wait_r; // Cycles the request has stood
	// Pulse ack once, only on a valid request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_r <= 4'h0;
			ack <= 1'b0;
		end else begin
			ack <= 1'b0;
			if (req.valid && !ack) begin
				wait_r <= wait_r + 4'h1;
				if (wait_r == lat) begin
					ack <= 1'b1;
					wait_r <= 4'h0;
				end
			end else
				wait_r <= 4'h0;
		end
	end
endmodule : core_model

// *** bench/tb_two_level_interrupt_enable_priority.sv ***
`timescale 1ns/1ps
module tb_two_level_interrupt_enable_priority;
	import irq_ctl_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [9:0]  adr = 10'h000;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [3:0]  be = 4'h1;
	logic [31:0] rdat;
	logic        wreq;
	logic [11:0] ev = 12'h000; // Event lines
	logic        baud = 1'b0;  // Timer 2 baud mode
	logic        ack;
	logic        reti = 1'b0;
	logic [3:0]  lat = 4'h0;   // Core answer delay
	logic        cke = 1'b1;   // Clock enable into the block
	core_req_t   req;
	logic        irq;
	logic [31:0] d;            // Last read data
	int          n_mismatch = 0;
	int          cmp_count = 0;
	always #12.5 clk = ~clk;
	irq_enable_priority_ctl u_dut (.CORE_CLK(clk), .SYS_RST(rst), .CLK_EN(cke), .AVS_ADDRESS(adr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
		.AVS_WAITREQUEST(wreq), .SRC_EVENT(ev), .T2_BAUD_MODE(baud), .CORE_ACK(ack), .CORE_RETI(reti),
		.CORE_REQ(req), .IRQ(irq));
	core_model u_core (.clk(clk), .rst(rst), .req(req), .lat(lat), .ack(ack));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Avalon access; waitrequest and read data taken at the same rising edge,
	// request released only at that edge
	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] b);
		int n;
		n = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= {idx, 2'b00};
		wdat <= wd;
		be <= b;
		@(posedge clk);
		while (wreq !== 1'b0 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n >= 50)
			n_mismatch++;
		d = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic fire(input int s);
		@(posedge clk);
		ev[s] <= 1'b1;
		@(posedge clk);
		ev[s] <= 1'b0;
	endtask : fire
	task automatic pulse_reti();
		@(posedge clk);
		reti <= 1'b1;
		@(posedge clk);
		reti <= 1'b0;
	endtask : pulse_reti
	// Request must show; then wait, unchecked, until it drops once the core takes it
	task automatic wait_req(input logic [3:0] vec, input logic hi);
		int n;
		n = 0;
		while (req.valid !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk("core request", {26'h0, req}, {26'h0, 1'b1, hi, vec});
		while (req.valid === 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
	endtask : wait_req
	task automatic quiet(input string nm);
		repeat (4) @(negedge clk);
		chk(nm, {31'h0, req.valid}, 32'h0);
	endtask : quiet
	task automatic t_regs();
		bus(0, IDX_ENABLE_MAIN, 0, 4'h1);
		chk("main enable", d, 32'h00);
		bus(0, IDX_ENABLE_PRIO_2, 0, 4'h1);
		chk("secondary", d, 32'ha0);
		bus(1, IDX_PRIORITY_MAIN, 32'hff, 4'h1);
		bus(0, IDX_PRIORITY_MAIN, 0, 4'h1);
		chk("main priority", d, 32'h7f);
		bus(1, IDX_ENABLE_PRIO_2, 32'hf7, 4'h1);
		bus(1, IDX_ENABLE_PRIO_2, 32'h00, 4'h0);
		bus(0, IDX_ENABLE_PRIO_2, 0, 4'h1);
		chk("secondary", d, 32'hf7);
		bus(1, IDX_PRIORITY_MAIN, 32'h00, 4'h1);
		bus(0, 8'h10, 0, 4'h1);
		chk("unmapped", d, 32'h0);
	endtask : t_regs
	task automatic t_irq();
		bus(1, IDX_EVENT_MASK, 32'h001, 4'h3);
		fire(1);
		fire(0);
		repeat (2) @(negedge clk);
		chk("irq line", {31'h0, irq}, 32'h1);
		bus(0, IDX_EVENT_STATUS, 0, 4'h3);
		chk("status", d, 32'h003);
		bus(1, IDX_EVENT_STATUS, 32'h001, 4'h3);
		@(negedge clk);
		chk("irq masked", {31'h0, irq}, 32'h0);
		baud <= 1'b1;
		fire(6);
		fire(7);
		bus(0, IDX_EVENT_STATUS, 0, 4'h3);
		chk("timer2 flags", d, 32'h082);
		baud <= 1'b0;
		fire(6);
		bus(0, IDX_EVENT_STATUS, 0, 4'h3);
		chk("timer2 flags", d, 32'h0c2);
		bus(1, IDX_EVENT_STATUS, 32'hfff, 4'h3);
	endtask : t_irq
	// Clock enable low freezes edge memory and status; event taken once enabled
	task automatic t_freeze();
		bus(1, IDX_EVENT_MASK, 32'h008, 4'h3);
		@(posedge clk);
		cke <= 1'b0;
		ev[3] <= 1'b1;
		repeat (3) @(negedge clk);
		chk("frozen irq", {31'h0, irq}, 32'h0);
		@(posedge clk);
		cke <= 1'b1;
		repeat (2) @(negedge clk);
		chk("thawed irq", {31'h0, irq}, 32'h1);
		@(posedge clk);
		ev[3] <= 1'b0;
		bus(0, IDX_EVENT_STATUS, 0, 4'h3);
		chk("thawed status", d, 32'h008);
		bus(1, IDX_EVENT_STATUS, 32'hfff, 4'h3);
	endtask : t_freeze
	// Each group alone: blocked without global, then vectored
	task automatic t_gate();
		int src[10] = '{0, 1, 2, 3, 4, 7, 8, 9, 10, 11};
		logic [7:0] en;
		logic [7:0] sec;
		for (int g = 0; g < 10; g++) begin
			en = (g < 7) ? 8'h01 << g : 8'h00;
			sec = (g < 7) ? 8'h00 : 8'h01 << (g - 7);
			bus(1, IDX_ENABLE_MAIN, {24'h0, en}, 4'h1);
			bus(1, IDX_ENABLE_PRIO_2, {24'h0, sec}, 4'h1);
			fire(src[g]);
			quiet("gated off");
			bus(1, IDX_ENABLE_MAIN, {24'h0, en | 8'h80}, 4'h1);
			wait_req(4'(g), 1'b0);
			bus(1, IDX_EVENT_STATUS, 32'hfff, 4'h3);
			pulse_reti();
		end
	endtask : t_gate
	// Slow core: high pre-empts low, nothing pre-empts high
	task automatic t_pre();
		lat <= 4'h6;
		bus(1, IDX_PRIORITY_MAIN, 32'h02, 4'h1);
		bus(1, IDX_ENABLE_MAIN, 32'h87, 4'h1);
		bus(1, IDX_ENABLE_PRIO_2, 32'h44, 4'h1);
		fire(0);
		wait_req(4'h0, 1'b0);
		fire(2);
		quiet("low on low");
		fire(11);
		wait_req(4'h9, 1'b1);
		fire(1);
		quiet("high on high");
		bus(1, IDX_EVENT_STATUS, 32'hffd, 4'h3);
		pulse_reti();
		wait_req(4'h1, 1'b1);
		bus(1, IDX_EVENT_STATUS, 32'hfff, 4'h3);
		pulse_reti();
		pulse_reti();
		bus(0, IDX_CORE_STATE, 0, 4'h1);
		chk("core state", d & 32'h3, 32'h0);
	endtask : t_pre
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_irq();
		t_freeze();
		t_gate();
		t_pre();
		report_and_stop();
	end
	// Watchdog, far beyond the run's few hundred cycles
	initial begin
		#500000;
		n_mismatch++;
		report_and_stop();
	end
endmodule : tb_two_level_interrupt_enable_priority
bind irq_enable_priority_ctl irq_ctl_checker u_chk (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.CORE_ACK(CORE_ACK), .CORE_RETI(CORE_RETI), .CORE_REQ(CORE_REQ), .IRQ(IRQ));
